//--- rtl/rtc_pkg.sv
// Constants, types and BCD helpers for the minute and hour counters
`default_nettype none
package rtc_pkg;

  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [15:0] MM_COUNT_ADDR = 16'hFFB3;
  localparam logic [15:0] HOURS_COUNT_ADDR = 16'hFFB4;
  localparam logic [15:0] CONTROL_ZERO_ADDR = 16'hFFB5;

  // Reset values
  localparam logic [7:0] MM_RESET = 8'h00;
  localparam logic [7:0] HOURS_RESET = 8'h12;
  localparam logic SELECT_RESET = 1'b0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Field layout
  localparam logic [7:0] MM_MASK = 8'h7F;
  localparam logic [7:0] HOUR_MASK = 8'h3F;
  localparam logic [7:0] HOUR12_MASK = 8'h1F;
  localparam int SELECT_BIT = 3;
  localparam int MERIDIAN_BIT = 5;
  localparam int MM_PEND_BIT = 1;
  localparam int HOUR_PEND_BIT = 0;

  // Binary limits of the counters
  localparam logic [7:0] MM_LAST = 8'h3B;
  localparam logic [7:0] HOUR24_LAST = 8'h17;
  localparam logic [7:0] HOUR12_LAST_AM = 8'h0B;
  localparam logic [7:0] HOUR12_TOP = 8'h0C;
  localparam logic [7:0] HOUR12_FIRST = 8'h01;
  localparam logic [7:0] BIN_ZERO = 8'h00;
  localparam logic [7:0] BIN_ONE = 8'h01;
  localparam logic [7:0] BIN_TEN = 8'h0A;

  // Timing of the buffered write, counted in subsystem clocks
  localparam int SUB_CLK_HZ = 32768;
  localparam int XFER_MAX_SUB_CLKS = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  function automatic logic [7:0] bcd_to_bin(input logic [7:0] b);
    logic [7:0] t;
    t = {4'h0, b[7:4]};
    return 8'((t << 3) + (t << 1) + {4'h0, b[3:0]});
  endfunction

  function automatic logic [7:0] bin_to_bcd(input logic [7:0] v);
    logic [7:0] q;
    logic [7:0] r;
    q = v / BIN_TEN;
    r = 8'(v - 8'(q * BIN_TEN));
    return {q[3:0], r[3:0]};
  endfunction

endpackage
`default_nettype wire

//--- rtl/rtc_write_buffer.sv
// Holding buffer that moves a software write into a counter on a sub tick
`timescale 1ns/1ps
`default_nettype none
module rtc_write_buffer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Software side
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  // Counter side
  input wire logic commit,
  output logic pending,
  output logic take,
  output logic [WIDTH-1:0] take_data
);

  logic pending_reg;
  logic [WIDTH-1:0] data_reg;

  // A fresh write beats a commit in the same cycle, so it is never lost
  assign take = commit & pending_reg & ~load;
  assign pending = pending_reg;
  assign take_data = data_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_reg <= 1'b0;
    end else if (load) begin
      pending_reg <= 1'b1;
    end else if (take) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_reg <= '0;
    end else if (load) begin
      data_reg <= load_data;
    end
  end

endmodule
`default_nettype wire

//--- rtl/rtc_hour_step.sv
// Hour advance and 12/24-hour conversion, purely combinational
`timescale 1ns/1ps
`default_nettype none
module rtc_hour_step (
  // Present value and systems
  input wire logic [7:0] hour_in,
  input wire logic sel24_old,
  input wire logic sel24_new,
  input wire logic step,
  // Result
  output logic [7:0] hour_out,
  output logic day_carry
);

  logic [7:0] b24;
  logic [7:0] b12;
  logic pm;
  logic [7:0] s_bin;
  logic s_pm;
  logic [7:0] o_bin;
  logic o_pm;

  assign b24 = rtc_pkg::bcd_to_bin(hour_in & rtc_pkg::HOUR_MASK);
  assign b12 = rtc_pkg::bcd_to_bin(hour_in & rtc_pkg::HOUR12_MASK);
  assign pm = hour_in[rtc_pkg::MERIDIAN_BIT];

  // Advance in the old system; illegal values fall back to a legal one
  always_comb begin
    s_pm = pm;
    day_carry = 1'b0;
    if (sel24_old) begin
      s_bin = b24;
      if (step) begin
        if (b24 >= rtc_pkg::HOUR24_LAST) begin
          s_bin = rtc_pkg::BIN_ZERO;
          day_carry = (b24 == rtc_pkg::HOUR24_LAST);
        end else begin
          s_bin = 8'(b24 + rtc_pkg::BIN_ONE);
        end
      end
    end else begin
      s_bin = b12;
      if (step) begin
        if (b12 == rtc_pkg::HOUR12_LAST_AM) begin
          // RULE17 - meridian flips at twelve
          s_bin = rtc_pkg::HOUR12_TOP;
          s_pm = ~pm;
          day_carry = pm;
        end else if (b12 >= rtc_pkg::HOUR12_TOP || b12 == rtc_pkg::BIN_ZERO)
        begin
          s_bin = rtc_pkg::HOUR12_FIRST;
        end else begin
          s_bin = 8'(b12 + rtc_pkg::BIN_ONE);
        end
      end
    end
  end

  // RULE11 - convert between systems
  always_comb begin
    o_bin = s_bin;
    o_pm = s_pm;
    if (sel24_old && !sel24_new) begin
      o_pm = (s_bin >= rtc_pkg::HOUR12_TOP);
      if (s_bin == rtc_pkg::BIN_ZERO) begin
        o_bin = rtc_pkg::HOUR12_TOP;
      end else if (s_bin > rtc_pkg::HOUR12_TOP) begin
        o_bin = 8'(s_bin - rtc_pkg::HOUR12_TOP);
      end
    end else if (!sel24_old && sel24_new) begin
      o_pm = 1'b0;
      if (s_bin == rtc_pkg::HOUR12_TOP) begin
        o_bin = s_pm ? rtc_pkg::HOUR12_TOP : rtc_pkg::BIN_ZERO;
      end else if (s_pm) begin
        o_bin = 8'(s_bin + rtc_pkg::HOUR12_TOP);
      end
    end
  end

  // RULE14 - meridian in bit 5 for 12-hour
  always_comb begin
    if (sel24_new) begin
      hour_out = rtc_pkg::bin_to_bcd(o_bin) & rtc_pkg::HOUR_MASK;
    end else begin
      hour_out = rtc_pkg::bin_to_bcd(o_bin) & rtc_pkg::HOUR12_MASK;
      hour_out[rtc_pkg::MERIDIAN_BIT] = o_pm;
    end
  end

endmodule
`default_nettype wire

//--- rtl/rtc_minute_hour_counters.sv
// Minute and hour counting stage with register port
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1 - minute counter holds BCD 0 to 59
// RULE2 - seconds overflow advances the minute
// RULE3 - writes buffered, applied within two sub clocks
// RULE4 - pending minute write beats seconds overflow
// RULE5 - illegal values recover after one count
// RULE6 - reset clears minute to zero
// RULE7 - minute bit 7 zero, BCD tens, units
// RULE8 - hour ranges per selected time system
// RULE9 - minute overflow advances the hour
// RULE10 - pending hour write beats minute overflow
// RULE11 - select change converts stored hour
// RULE12 - reset sets hour to BCD twelve
// RULE13 - 24-hour after reset reads zero
// RULE14 - hour bit 5 is meridian in 12-hour
// RULE15 - hour bits 7,6 zero, BCD tens, units
// RULE16 - software uses single byte accesses
// RULE17 - twelve goes to one, eleven flips meridian
module rtc_minute_hour_counters (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire rtc_pkg::bus_req_t bus_req,
  output logic [rtc_pkg::DATA_W-1:0] rdata,
  // Counter chain
  input wire logic sub_tick,
  input wire logic sec_overflow,
  output logic day_overflow,
  // Current state
  output logic [7:0] minute_value,
  output logic [7:0] hour_value,
  output logic twelve_24_select
);

  logic [7:0] mm_count_reg;
  logic [7:0] mm_count_next;
  logic [7:0] hours_count_reg;
  logic sel24_reg;
  logic sel24_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic day_overflow_reg;
  logic [7:0] mm_bin;
  logic mm_step;
  logic mm_carry;
  logic hour_step;
  logic [7:0] hour_stepped;
  logic hour_day_carry;
  logic mm_load;
  logic hour_load;
  logic ctrl_write;
  logic mm_pending;
  logic mm_take;
  logic [7:0] mm_take_data;
  logic hour_pending;
  logic hour_take;
  logic [7:0] hour_take_data;

  // Single decode of the address; the strobe is ANDed in at each use
  function automatic logic hits(input rtc_pkg::bus_req_t r,
                                input logic [15:0] a);
    return r.addr == a;
  endfunction

  // RULE16 - each strobe moves one whole byte
  assign mm_load = bus_req.wr & hits(bus_req, rtc_pkg::MM_COUNT_ADDR);
  assign hour_load = bus_req.wr & hits(bus_req, rtc_pkg::HOURS_COUNT_ADDR);
  assign ctrl_write = bus_req.wr & hits(bus_req, rtc_pkg::CONTROL_ZERO_ADDR);

  // RULE3 - buffer then transfer on sub tick
  rtc_write_buffer #(
    .WIDTH(8)
  ) u_mm_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(mm_load),
    .load_data(bus_req.wdata & rtc_pkg::MM_MASK),
    .commit(sub_tick),
    .pending(mm_pending),
    .take(mm_take),
    .take_data(mm_take_data)
  );

  // RULE3 - hour buffered likewise
  rtc_write_buffer #(
    .WIDTH(8)
  ) u_hour_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(hour_load),
    .load_data(bus_req.wdata & rtc_pkg::HOUR_MASK),
    .commit(sub_tick),
    .pending(hour_pending),
    .take(hour_take),
    .take_data(hour_take_data)
  );

  // RULE4 - no counting while a minute write waits
  assign mm_step = sec_overflow & ~mm_pending;
  assign mm_bin = rtc_pkg::bcd_to_bin(mm_count_reg);
  assign mm_carry = mm_step & (mm_bin == rtc_pkg::MM_LAST);

  // RULE2 - advance one minute per seconds overflow
  always_comb begin
    mm_count_next = mm_count_reg;
    if (mm_take) begin
      mm_count_next = mm_take_data;
    end else if (mm_step) begin
      // RULE5 - out of range returns to zero
      if (mm_bin >= rtc_pkg::MM_LAST) begin
        mm_count_next = rtc_pkg::MM_RESET;
      end else begin
        mm_count_next = rtc_pkg::bin_to_bcd(8'(mm_bin + rtc_pkg::BIN_ONE));
      end
    end
  end

  // RULE6 - minute clears on reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mm_count_reg <= rtc_pkg::MM_RESET;
    end else begin
      // RULE7 - bit 7 held at zero
      mm_count_reg <= mm_count_next & rtc_pkg::MM_MASK;
    end
  end

  // RULE10 - hour write pending ignores minute carry
  assign hour_step = mm_carry & ~hour_pending;

  // RULE11 - a select write changes the system
  assign sel24_next = ctrl_write ? bus_req.wdata[rtc_pkg::SELECT_BIT]
                                 : sel24_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel24_reg <= rtc_pkg::SELECT_RESET;
    end else begin
      sel24_reg <= sel24_next;
    end
  end

  // RULE9 - minute carry advances the hour
  rtc_hour_step u_hour_step (
    .hour_in(hours_count_reg),
    .sel24_old(sel24_reg),
    .sel24_new(sel24_next),
    .step(hour_step),
    .hour_out(hour_stepped),
    .day_carry(hour_day_carry)
  );

  // RULE12 - hour resets to twelve, AM
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hours_count_reg <= rtc_pkg::HOURS_RESET;
    end else if (hour_take) begin
      // RULE8 - software supplies a value for the system
      hours_count_reg <= hour_take_data & rtc_pkg::HOUR_MASK;
    end else if (hour_step || (sel24_next != sel24_reg)) begin
      // Illegal values stay readable until the next count or select change
      // RULE13 - twelve AM converts to zero
      // RULE15 - bits 7 and 6 held at zero
      hours_count_reg <= hour_stepped & rtc_pkg::HOUR_MASK;
    end
  end

  // Day carry pulse toward the day counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      day_overflow_reg <= 1'b0;
    end else begin
      day_overflow_reg <= hour_day_carry & ~hour_take;
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_next = rtc_pkg::READ_ZERO;
    if (bus_req.rd) begin
      if (hits(bus_req, rtc_pkg::MM_COUNT_ADDR)) begin
        rdata_next = mm_count_reg;
      end else if (hits(bus_req, rtc_pkg::HOURS_COUNT_ADDR)) begin
        rdata_next = hours_count_reg;
      end else if (hits(bus_req, rtc_pkg::CONTROL_ZERO_ADDR)) begin
        rdata_next[rtc_pkg::SELECT_BIT] = sel24_reg;
        rdata_next[rtc_pkg::MM_PEND_BIT] = mm_pending;
        rdata_next[rtc_pkg::HOUR_PEND_BIT] = hour_pending;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= rtc_pkg::READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign day_overflow = day_overflow_reg;
  assign minute_value = mm_count_reg;
  assign hour_value = hours_count_reg;
  assign twelve_24_select = sel24_reg;

endmodule
`default_nettype wire

//--- verif/rtc_minute_hour_counters_asserts.sv
// Port assertions for the minute and hour counting stage
`timescale 1ns/1ps
`default_nettype none
module rtc_mh_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire rtc_pkg::bus_req_t bus_req,
  input wire logic [rtc_pkg::DATA_W-1:0] rdata,
  // Counter chain and state
  input wire logic sub_tick,
  input wire logic sec_overflow,
  input wire logic day_overflow,
  input wire logic [7:0] minute_value,
  input wire logic [7:0] hour_value,
  input wire logic twelve_24_select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_values: assert property (
    $past(rst) |-> minute_value == 8'h00 && hour_value == 8'h12)
    else $error("counters not at reset values");
  a_fixed_zero_bits: assert property (
    minute_value[7] == 1'b0 && hour_value[7:6] == 2'b00)
    else $error("fixed zero bit set");
  a_minute_cause: assert property (
    minute_value != $past(minute_value) |-> $past(sec_overflow) ||
    $past(sub_tick)) else $error("minute moved without cause");
  a_hour_carry: assert property (
    hour_value != $past(hour_value) && !$past(sub_tick) &&
    $stable(twelve_24_select) |-> $past(sec_overflow) &&
    $past(minute_value) == 8'h59) else $error("hour moved without carry");
  a_meridian_flip: assert property (
    !twelve_24_select && $stable(twelve_24_select) && !$past(sub_tick) &&
    $past(hour_value[4:0]) == 5'h11 && hour_value != $past(hour_value)
    |-> hour_value[4:0] == 5'h12 && hour_value[5] != $past(hour_value[5]))
    else $error("eleven to twelve wrong");
  a_day_cause: assert property (
    day_overflow |-> $past(sec_overflow) &&
    (hour_value == 8'h00 || hour_value == 8'h12))
    else $error("day pulse without wrap");
  a_read_minute: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == 16'hFFB3
    |-> rdata == $past(minute_value)) else $error("minute read wrong");
  a_read_hour: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == 16'hFFB4
    |-> rdata == $past(hour_value)) else $error("hour read wrong");
  a_read_idle: assert property (
    !$past(bus_req.rd) |-> rdata == 8'h00) else $error("read data not idle");
endmodule
bind rtc_minute_hour_counters rtc_mh_checker u_rtc_mh_checker (
  .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
  .sub_tick(sub_tick), .sec_overflow(sec_overflow),
  .day_overflow(day_overflow), .minute_value(minute_value),
  .hour_value(hour_value), .twelve_24_select(twelve_24_select));
`default_nettype wire

//--- verif/rtc_minute_hour_counters_tb_top.sv
// Self-checking bench for the minute and hour counting stage
`timescale 1ns/1ps
`default_nettype none
module rtc_minute_hour_counters_tb_top;
  // Short sub period keeps the run brief
  localparam int SUBP = 16;
  localparam logic [15:0] MM = rtc_pkg::MM_COUNT_ADDR;
  localparam logic [15:0] HR = rtc_pkg::HOURS_COUNT_ADDR;
  localparam logic [15:0] CTL = rtc_pkg::CONTROL_ZERO_ADDR;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  rtc_pkg::bus_req_t bus_req = '0;
  logic sub_tick = 1'b0;
  logic sec_overflow = 1'b0;
  logic [7:0] rdata;
  logic day_overflow;
  logic [7:0] minute_value;
  logic [7:0] hour_value;
  logic twelve_24_select;
  int err_count = 0;
  int checked = 0;
  int sub_cnt = 0;
  logic [15:0] lfsr = 16'h73F3;
  logic [7:0] m;
  logic [7:0] e;
  int t;
  rtc_minute_hour_counters u_rtc_minute_hour_counters (
    .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .sub_tick(sub_tick), .sec_overflow(sec_overflow),
    .day_overflow(day_overflow), .minute_value(minute_value),
    .hour_value(hour_value), .twelve_24_select(twelve_24_select));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    sub_cnt <= (sub_cnt == SUBP - 1) ? 0 : sub_cnt + 1;
    sub_tick <= (sub_cnt == SUBP - 2);
  end
  function automatic logic [15:0] nxt(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v == 8'h59) return 8'h00;
    if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return v + 8'h01;
  endfunction
  task automatic conclude();
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Buffered write, then the commit window of two sub periods
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    wr(a, d);
    cyc(2 * SUBP + 1);
  endtask
  task automatic sec(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      sec_overflow <= 1'b1;
    end
    @(posedge ref_clk);
    sec_overflow <= 1'b0;
    #1;
  endtask
  // Puts the next write far from a commit tick
  task automatic align();
    int i;
    for (i = 0; i <= SUBP; i++) begin
      @(posedge ref_clk);
      if (sub_tick) break;
    end
    if (i > SUBP) begin
      err_count++;
      conclude();
    end
  endtask
  task automatic carry(input logic [7:0] h, input logic [7:0] exp);
    put(HR, h);
    put(MM, 8'h59);
    sec(1);
    chk(hour_value, exp);
  endtask
  initial begin
    cyc(20000);
    err_count++;
    conclude();
  end
  initial begin
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    rd(MM, rtc_pkg::MM_RESET);
    rd(HR, 8'h12);
    rd(16'hFFB6, 8'h00);
    wr(CTL, 8'h08);
    chk(hour_value, 8'h00);
    chk({7'h00, twelve_24_select}, 8'h01);
    rd(CTL, 8'h08);
    carry(8'h23, 8'h00);
    chk(minute_value, 8'h00);
    chk({7'h00, day_overflow}, 8'h01);
    @(posedge ref_clk);
    #1;
    chk({7'h00, day_overflow}, 8'h00);
    align();
    wr(MM, 8'h30);
    rd(CTL, 8'h0A);
    sec(1);
    chk(minute_value, 8'h00);
    cyc(2 * SUBP);
    chk(minute_value, 8'h30);
    put(MM, 8'h59);
    align();
    wr(HR, 8'h05);
    rd(CTL, 8'h09);
    sec(1);
    chk(hour_value, 8'h00);
    cyc(2 * SUBP);
    chk(hour_value, 8'h05);
    put(MM, 8'hFF);
    rd(MM, 8'h7F);
    sec(1);
    chk(minute_value, 8'h00);
    put(HR, 8'hFF);
    rd(HR, 8'h3F);
    carry(8'h3F, 8'h00);
    put(HR, 8'h13);
    wr(CTL, 8'h00);
    chk(hour_value, 8'h21);
    chk({7'h00, twelve_24_select}, 8'h00);
    carry(8'h11, 8'h32);
    carry(8'h32, 8'h21);
    carry(8'h31, 8'h12);
    put(HR, 8'h21);
    wr(CTL, 8'h08);
    chk(hour_value, 8'h13);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      t = (int'(lfsr[2:0]) % 6) * 16 + int'(lfsr[7:4]) % 10;
      m = 8'(t);
      put(MM, m);
      e = m;
      repeat (int'(lfsr[9:8]) + 1) e = bcd_inc(e);
      sec(int'(lfsr[9:8]) + 1);
      chk(minute_value, e);
      rd(MM, e);
    end
    @(posedge ref_clk);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    #1;
    chk(hour_value, 8'h12);
    chk(minute_value, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
